/* hw/pli_port_led_indicator.sv */
// What this block does
// - Mode code captured after reset release selects mapping
// - Lamp zero active low, speed or collision
// - Mapping one lamp zero: speed, link, blink
// - Lamp one shows full duplex, maps 0-2
// - Mapping three lamp two: duplex plus collision
// - Lamp three: link, blinking on traffic
// - Lamp three: receive, or 100M link
// - Pins undriven during reset, driven after
`timescale 1ns/10ps
`default_nettype none
`include "pli_params.svh"
module pli_port_led_indicator
   import pli_pkg::*;
(
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        reset,
   input  wire logic                        clockEnable,
   // Mode strap pins
   input  wire logic [3:0]                  indicatorMapSelect,
   // Port status
   input  wire pli_pkg::pli_port_s [8:0]    portStatus,
   // Indicator pins
   output logic [8:0]                       portIndicatorZero,
   output logic [8:0]                       portIndicatorOne,
   output logic [8:0]                       portIndicatorTwo,
   output logic [8:0]                       portIndicatorThree,
   output logic [35:0]                      indicatorOe_n,
   output logic                             factoryTestMode
);
   import pli_pkg::*;

   logic [3:0]  mapSel_q;
   logic        captured_q;
   logic        drive_q;
   pli_map_e    map;
   logic [8:0]  slowOn, fastOn, actBusy, collOn, collBusy;
   logic [8:0]  lit0_d, lit1_d, lit2_d, lit3_d;

   // Lit on link; dark blink phases only while traffic is seen
   function automatic logic link_lamp(input logic up, input logic busyAct, input logic phase);
      return up && !(busyAct && !phase);
   endfunction : link_lamp

   // Strap caught by the clock after release, never by the async reset
   always_ff @(posedge clock or posedge reset)
      if (reset)
      begin
         mapSel_q   <= `PLI_MAP_RESET;
         captured_q <= 1'b0;
      end
      else if (clockEnable && !captured_q)
      begin
         mapSel_q   <= indicatorMapSelect;
         captured_q <= 1'b1;
      end

   // Output drivers wait until the strap is held
   always_ff @(posedge clock or posedge reset)
      if (reset)
         drive_q <= 1'b0;
      else if (clockEnable)
         drive_q <= captured_q;

   assign map             = pli_map_e'(mapSel_q[1:0]);
   // Test codes keep the normal decode of the low bits, so code 6 runs mapping two
   assign factoryTestMode = mapSel_q[3] | mapSel_q[2];

   genvar p;
   generate
      for (p = 0; p < `PLI_NUM_PORTS; p++)
      begin : g_port
         logic act;
         assign act = portStatus[p].txActive | portStatus[p].rxActive;
         pli_blinker #(.HALF(`PLI_SLOW_HALF_CYC)) u_slow
         (
            .clock      (clock),
            .reset      (reset),
            .clockEnable(clockEnable),
            .event_i    (act),
            .blinkOn    (slowOn[p]),
            .busy       (actBusy[p])
         );
         pli_blinker #(.HALF(`PLI_FAST_HALF_CYC)) u_fast
         (
            .clock      (clock),
            .reset      (reset),
            .clockEnable(clockEnable),
            .event_i    (act),
            .blinkOn    (fastOn[p]),
            .busy       ()
         );
         pli_blinker #(.HALF(`PLI_FAST_HALF_CYC)) u_coll
         (
            .clock      (clock),
            .reset      (reset),
            .clockEnable(clockEnable),
            .event_i    (portStatus[p].collision),
            .blinkOn    (collOn[p]),
            .busy       (collBusy[p])
         );
      end
   endgenerate

   // Lit flags per port, decoded from the selected mapping
   always_comb
   begin
      for (int i = 0; i < `PLI_NUM_PORTS; i++)
      begin
         lit0_d[i] = 1'b0;
         lit1_d[i] = 1'b0;
         lit2_d[i] = 1'b0;
         lit3_d[i] = 1'b0;
         case (map)
            PLI_MAP0:
            begin
               lit0_d[i] = portStatus[i].speed100;
               lit1_d[i] = portStatus[i].fullDuplex;
               lit2_d[i] = portStatus[i].collision;
               lit3_d[i] = link_lamp(portStatus[i].linkUp, actBusy[i], slowOn[i]);
            end
            PLI_MAP1:
            begin
               // Link steady, blink gaps only while traffic
               lit0_d[i] = link_lamp(portStatus[i].linkUp, actBusy[i],
                  portStatus[i].speed100 ? fastOn[i] : slowOn[i]);
               lit1_d[i] = portStatus[i].fullDuplex;
               lit2_d[i] = portStatus[i].txActive;
               lit3_d[i] = portStatus[i].rxActive;
            end
            PLI_MAP2:
            begin
               lit0_d[i] = portStatus[i].collision;
               lit1_d[i] = portStatus[i].fullDuplex;
               lit2_d[i] = portStatus[i].linkUp && !portStatus[i].speed100;
               lit3_d[i] = portStatus[i].linkUp && portStatus[i].speed100;
            end
            PLI_MAP3:
            begin
               lit0_d[i] = portStatus[i].speed100;
               lit1_d[i] = 1'b0;
               lit2_d[i] = portStatus[i].fullDuplex || (collBusy[i] && collOn[i]);
               lit3_d[i] = link_lamp(portStatus[i].linkUp, actBusy[i], slowOn[i]);
            end
            default:
            begin
               lit0_d[i] = 1'b0;
            end
         endcase
      end
   end

   // Active-low pin registers; dark (high) until driving starts
   always_ff @(posedge clock or posedge reset)
      if (reset)
      begin
         portIndicatorZero  <= 9'h1ff;
         portIndicatorOne   <= 9'h1ff;
         portIndicatorTwo   <= 9'h1ff;
         portIndicatorThree <= 9'h1ff;
      end
      else if (clockEnable)
      begin
         portIndicatorZero  <= drive_q ? ~lit0_d : 9'h1ff;
         portIndicatorOne   <= drive_q ? ~lit1_d : 9'h1ff;
         portIndicatorTwo   <= drive_q ? ~lit2_d : 9'h1ff;
         portIndicatorThree <= drive_q ? ~lit3_d : 9'h1ff;
      end

   assign indicatorOe_n = drive_q ? 36'h000000000 : 36'hfffffffff;

   undriven_in_reset_a: assert property (@(posedge clock) reset |-> indicatorOe_n == 36'hfffffffff)
      else $error("indicator pins driven in reset");
   drive_after_capture_a: assert property (@(posedge clock) disable iff (reset)
      $rose(captured_q) && clockEnable |=> drive_q)
      else $error("drive not enabled after capture");
   strap_held_a: assert property (@(posedge clock) disable iff (reset)
      captured_q && $past(captured_q) |-> $stable(mapSel_q))
      else $error("map select changed after capture");
   speed_lamp_a: assert property (@(posedge clock) disable iff (reset)
      clockEnable && drive_q && (map == PLI_MAP0 || map == PLI_MAP3)
      |=> portIndicatorZero[0] == !$past(portStatus[0].speed100))
      else $error("speed lamp wrong");
   duplex_lamp_a: assert property (@(posedge clock) disable iff (reset)
      clockEnable && drive_q && map != PLI_MAP3
      |=> portIndicatorOne[0] == !$past(portStatus[0].fullDuplex))
      else $error("duplex lamp wrong");
   rx_lamp_a: assert property (@(posedge clock) disable iff (reset)
      clockEnable && drive_q && map == PLI_MAP1
      |=> portIndicatorThree[0] == !$past(portStatus[0].rxActive))
      else $error("receive lamp wrong");
   link_down_dark_a: assert property (@(posedge clock) disable iff (reset)
      clockEnable && drive_q && map == PLI_MAP0 && !portStatus[0].linkUp
      |=> portIndicatorThree[0])
      else $error("link lamp lit with link down");
   map2_lamp_two_a: assert property (@(posedge clock) disable iff (reset)
      clockEnable && drive_q && map == PLI_MAP2
      |=> portIndicatorTwo[0] == !$past(portStatus[0].linkUp && !portStatus[0].speed100))
      else $error("10M link lamp wrong");
   full_duplex_lit_a: assert property (@(posedge clock) disable iff (reset)
      clockEnable && drive_q && map == PLI_MAP3 && portStatus[0].fullDuplex
      |=> !portIndicatorTwo[0])
      else $error("full duplex lamp dark");

   map1_seen_c: cover property (@(posedge clock) drive_q && map == PLI_MAP1);
   map3_coll_c: cover property (@(posedge clock) drive_q && map == PLI_MAP3 && collBusy[0]);
   blink_c: cover property (@(posedge clock) drive_q && actBusy[0] && !portIndicatorThree[0]);
endmodule : pli_port_led_indicator
`default_nettype wire

/* hw/pli_params.svh */
`ifndef PLI_PARAMS_SVH
`define PLI_PARAMS_SVH
`define PLI_NUM_PORTS      9
`define PLI_MAP_ZERO       4'h0
`define PLI_MAP_ONE        4'h1
`define PLI_MAP_TWO        4'h2
`define PLI_MAP_THREE      4'h3
`define PLI_MAP_RESET      4'h0
`define PLI_SLOW_HALF_NS   80
`define PLI_FAST_HALF_NS   20
`define PLI_CLOCK_NS       10
`define PLI_SLOW_HALF_CYC  (`PLI_SLOW_HALF_NS / `PLI_CLOCK_NS)
`define PLI_FAST_HALF_CYC  (`PLI_FAST_HALF_NS / `PLI_CLOCK_NS)
`define PLI_STRETCH_CYC    16
`endif

/* hw/pli_pkg.sv */
package pli_pkg;
   typedef enum logic [1:0]
   {
      PLI_MAP0 = 2'b00,
      PLI_MAP1 = 2'b01,
      PLI_MAP2 = 2'b10,
      PLI_MAP3 = 2'b11
   } pli_map_e;

   typedef struct packed
   {
      logic linkUp;
      logic speed100;
      logic fullDuplex;
      logic collision;
      logic txActive;
      logic rxActive;
   } pli_port_s;

   typedef logic [3:0] pli_lamps_t;
endpackage : pli_pkg

/* hw/pli_blinker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pli_params.svh"
// Free-running blink phase; events are stretched so short frames still show
module pli_blinker
#(
   parameter int unsigned HALF = 2
)
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic clockEnable,
   // Activity
   input  wire logic event_i,
   output logic      blinkOn,
   output logic      busy
);
   logic [15:0] phase_q;
   logic [4:0]  stretch_q;
   logic        toggle_q;

   always_ff @(posedge clock or posedge reset)
      if (reset)
      begin
         phase_q  <= 16'h0000;
         toggle_q <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (phase_q >= 16'(HALF - 1))
         begin
            phase_q  <= 16'h0000;
            toggle_q <= ~toggle_q;
         end
         else
            phase_q <= phase_q + 16'h0001;
      end

   always_ff @(posedge clock or posedge reset)
      if (reset)
         stretch_q <= 5'h00;
      else if (clockEnable)
      begin
         if (event_i)
            stretch_q <= 5'(`PLI_STRETCH_CYC);
         else if (stretch_q != 5'h00)
            stretch_q <= stretch_q - 5'h01;
      end

   assign busy    = event_i || (stretch_q != 5'h00);
   assign blinkOn = busy && toggle_q;
endmodule : pli_blinker
`default_nettype wire

/* tb/pli_lamp_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pli_lamp_model
(
   // Pin drivers
   input  wire logic [35:0] pinOut,
   input  wire logic [35:0] pinOe_n,
   // Lamps seen on the board
   output logic [35:0]      lit
);
   // Released pins float to the pull-up, which leaves the lamp dark
   always_comb lit = ~(pinOut | pinOe_n);
endmodule : pli_lamp_model
`default_nettype wire

/* tb/tb_pli_port_led_indicator.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_pli_port_led_indicator;
   import pli_pkg::*;
   logic            clock = 0, reset = 1, clockEnable = 1, testMode;
   logic [3:0]      mapSel = 4'h0;
   pli_port_s [8:0] status = '0;
   logic [8:0]      lampZ, lampO, lampT, lampH;
   logic [35:0]     oe_n, lit, held, expQ[$];
   logic [15:0]     lfsr = 16'hbb62;
   int              mismatches = 0, comparisons = 0, slowF, fastF, on, fl;
   event            sample;
   always #5 clock = ~clock;
   pli_port_led_indicator pli_port_led_indicator_i (.clock(clock), .reset(reset),
      .clockEnable(clockEnable), .indicatorMapSelect(mapSel), .portStatus(status),
      .portIndicatorZero(lampZ), .portIndicatorOne(lampO), .portIndicatorTwo(lampT),
      .portIndicatorThree(lampH), .indicatorOe_n(oe_n), .factoryTestMode(testMode));
   pli_lamp_model pli_lamp_model_i (.pinOut({lampH, lampT, lampO, lampZ}),
      .pinOe_n(oe_n), .lit(lit));
   task automatic fail(input string msg);
      $display("wrong value at %0t: %s", $time, msg);
      mismatches++;
   endtask : fail
   task automatic cmp_bit(input logic got, input logic exp, input string msg);
      comparisons++;
      if (got !== exp) fail(msg);
   endtask : cmp_bit
   task automatic note_lamps(input logic [35:0] e);
      expQ.push_back(e);
      ->sample;
   endtask : note_lamps
   task automatic cmp_lamps(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) fail("lamp pattern");
   endtask : cmp_lamps
   // Watcher takes the oldest note whenever a lamp snapshot is due
   always @(sample)
      cmp_lamps(lit, expQ.pop_front());
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // Steady lamp picture; blinking cases are kept out of it by the stimulus
   function automatic logic [35:0] exp_lit(input logic [1:0] m);
      logic [35:0] e;
      pli_port_s   s;
      e = '0;
      for (int p = 0; p < 9; p++)
      begin
         s = status[p];
         case (m)
            2'h0: {e[27+p], e[18+p], e[9+p], e[p]} = {s.linkUp, s.collision, s.fullDuplex, s.speed100};
            2'h1: {e[27+p], e[18+p], e[9+p], e[p]} = {s.rxActive, s.txActive, s.fullDuplex, s.linkUp};
            2'h2: {e[27+p], e[18+p], e[9+p], e[p]} = {s.linkUp & s.speed100,
                     s.linkUp & ~s.speed100, s.fullDuplex, s.collision};
            default: {e[27+p], e[18+p], e[9+p], e[p]} = {s.linkUp, s.fullDuplex, 1'b0, s.speed100};
         endcase
      end
      return e;
   endfunction : exp_lit
   task automatic set_all(input logic [5:0] v);
      @(posedge clock);
      for (int p = 0; p < 9; p++) status[p] <= pli_port_s'(v);
   endtask : set_all
   task automatic start(input logic [3:0] code);
      @(posedge clock);
      mapSel <= code;
      reset  <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      note_lamps('0);
      cmp_bit(&oe_n, 1'b1, "pins driven in reset");
      @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      mapSel <= code ^ 4'h3;
      repeat (3) @(posedge clock);
      @(negedge clock);
      cmp_bit(|oe_n, 1'b0, "pins not driven");
      cmp_bit(testMode, |code[3:2], "test flag");
   endtask : start
   task automatic watch(input int idx);
      logic prev;
      on   = 0;
      fl   = 0;
      prev = lit[idx];
      repeat (64)
      begin
         @(negedge clock);
         on += int'(lit[idx] === 1'b1);
         fl += int'(lit[idx] !== prev);
         prev = lit[idx];
      end
   endtask : watch
   initial
   begin
      for (int c = 0; c < 5; c++)
      begin
         start(c == 4 ? 4'h6 : 4'(c));
         repeat (6)
         begin
            @(posedge clock);
            for (int p = 0; p < 9; p++)
            begin
               lfsr = lfsr_next(lfsr);
               status[p] <= pli_port_s'(lfsr[5:0] & (c[0] ? 6'h38 : c == 2 ? 6'h3f : 6'h3c));
            end
            repeat (20) @(posedge clock);
            @(negedge clock);
            note_lamps(exp_lit(c == 4 ? 2'h2 : 2'(c)));
         end
      end
      // Frozen lamps must keep the picture of the status before the change
      held = exp_lit(2'h2);
      set_all(6'h3f);
      clockEnable <= 1'b0;
      repeat (5) @(negedge clock);
      note_lamps(held);
      @(posedge clock);
      clockEnable <= 1'b1;
      start(4'h0);
      set_all(6'h22);
      watch(27);
      cmp_bit(on > 0 && on < 64, 1'b1, "link lamp not blinking");
      start(4'h3);
      set_all(6'h24);
      watch(18);
      cmp_bit(on > 0 && on < 64, 1'b1, "collision lamp steady");
      start(4'h1);
      set_all(6'h21);
      watch(0);
      slowF = fl;
      cmp_bit(lit[27], 1'b1, "receive lamp dark");
      set_all(6'h31);
      watch(0);
      fastF = fl;
      cmp_bit(fastF > slowF && slowF > 0, 1'b1, "blink rates");
      tally_and_finish();
   end
endmodule : tb_pli_port_led_indicator
`default_nettype wire
